//--- verilog/mq_pkg.sv
// constants, carriers and decode helpers for the message queue pointer block
package mq_pkg;

  localparam int unsigned NUM_PTR = 6;
  localparam int unsigned NUM_OWN = 3;
  localparam int unsigned OFS_W = 18;
  localparam int unsigned BASE_W = 12;
  localparam int unsigned OFS_LSB = 2;
  localparam int unsigned BASE_LSB = 20;

  // byte offsets on the register bus
  localparam logic [11:0] CTRL_OFS = 12'h200;
  localparam logic [11:0] IN_FREE_BOT_OFS = 12'h208;
  localparam logic [11:0] IN_POST_TOP_OFS = 12'h20C;
  localparam logic [11:0] IN_POST_BOT_OFS = 12'h210;
  localparam logic [11:0] OUT_FREE_TOP_OFS = 12'h214;
  localparam logic [11:0] OUT_FREE_BOT_OFS = 12'h218;
  localparam logic [11:0] OUT_POST_TOP_OFS = 12'h21C;

  // storage index of each pointer
  localparam logic [2:0] IDX_IN_FREE_BOT = 3'h0;
  localparam logic [2:0] IDX_IN_POST_TOP = 3'h1;
  localparam logic [2:0] IDX_IN_POST_BOT = 3'h2;
  localparam logic [2:0] IDX_OUT_FREE_TOP = 3'h3;
  localparam logic [2:0] IDX_OUT_FREE_BOT = 3'h4;
  localparam logic [2:0] IDX_OUT_POST_TOP = 3'h5;
  // pointers the device advances, by advance request number
  localparam logic [2:0][2:0] OWNED_IDX = {IDX_OUT_FREE_TOP, IDX_IN_POST_TOP, IDX_IN_FREE_BOT};

  // control register fields
  localparam int unsigned CTRL_DIS_BIT = 0;
  localparam int unsigned CTRL_RRBP_BIT = 1;
  localparam int unsigned CTRL_SIZE_LSB = 4;
  localparam int unsigned CTRL_SIZE_MSB = 6;

  // values after reset
  localparam logic [OFS_W-1:0] PTR_RST = 18'h00000;
  localparam logic [BASE_W-1:0] BASE_RST = 12'h000;
  localparam logic [2:0] SIZE_RST = 3'h0;
  localparam logic RRBP_RST = 1'b0;
  localparam logic DIS_RST = 1'b0;

  localparam logic [2:0] SIZE_256 = 3'h0;
  localparam logic [2:0] SIZE_64K = 3'h4;
  localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] RD_ZERO = 32'h00000000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mq_apb_req_s;

  typedef struct packed {
    logic hit;
    logic is_ctrl;
    logic [2:0] idx;
  } mq_dec_s;

  function automatic mq_dec_s mq_decode(input logic [11:0] addr);
    mq_dec_s d;
    d = '{hit: 1'b1, is_ctrl: 1'b0, idx: 3'h0};
    unique case (addr)
      CTRL_OFS: d.is_ctrl = 1'b1;
      IN_FREE_BOT_OFS: d.idx = IDX_IN_FREE_BOT;
      IN_POST_TOP_OFS: d.idx = IDX_IN_POST_TOP;
      IN_POST_BOT_OFS: d.idx = IDX_IN_POST_BOT;
      OUT_FREE_TOP_OFS: d.idx = IDX_OUT_FREE_TOP;
      OUT_FREE_BOT_OFS: d.idx = IDX_OUT_FREE_BOT;
      OUT_POST_TOP_OFS: d.idx = IDX_OUT_POST_TOP;
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction

  // word-index bits that wrap for a queue size code
  function automatic logic [OFS_W-1:0] mq_wrap_mask(input logic [2:0] size);
    logic [OFS_W-1:0] m;
    unique case (size)
      3'h0: m = 18'h000FF;
      3'h1: m = 18'h003FF;
      3'h2: m = 18'h00FFF;
      3'h3: m = 18'h03FFF;
      default: m = 18'h0FFFF;
    endcase
    return m;
  endfunction

endpackage

//--- verilog/mq_ptr_adv.sv
// advance of one device-owned queue pointer with wrap at the queue size
`timescale 1ns/1ps
module mq_ptr_adv (
  input wire logic [mq_pkg::OFS_W-1:0] i_offset,
  input wire logic [2:0] i_size,
  input wire logic i_use,
  input wire logic i_disabled,
  output logic o_take,
  output logic [mq_pkg::OFS_W-1:0] o_next
);
  import mq_pkg::*;

  logic [OFS_W-1:0] mask;
  logic [OFS_W-1:0] inc;

  always_comb begin
    mask = mq_wrap_mask(i_size);
    inc = i_offset + 18'h00001;
    o_next = (i_offset & ~mask) | (inc & mask);
    o_take = i_use & ~i_disabled;
  end

endmodule

//--- verilog/mq_apb_slv.sv
// apb slave front end: decode, zero-wait answer, registered read data
`timescale 1ns/1ps
module mq_apb_slv (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire mq_pkg::mq_apb_req_s i_apb,
  input wire logic [31:0] i_rdata,
  output mq_pkg::mq_dec_s o_dec,
  output logic o_wr,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  import mq_pkg::*;

  logic [31:0] prdata_ff;
  logic setup;
  logic access;

  always_comb begin
    o_dec = mq_decode(i_apb.paddr);
    setup = i_apb.psel & ~i_apb.penable;
    access = i_apb.psel & i_apb.penable;
    o_pready = access;
    o_pslverr = access & ~o_dec.hit;
    o_wr = access & i_apb.pwrite & o_dec.hit;
  end

  // read word caught in setup, shown through the access phase
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      prdata_ff <= RD_ZERO;
    end else if (setup) begin
      prdata_ff <= (i_apb.pwrite | ~o_dec.hit) ? RD_ZERO : i_rdata;
    end
  end

  assign o_prdata = prdata_ff;

endmodule

//--- verilog/mq_queue_ptrs.sv
// message queue pointer registers with device-side pointer advance
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module mq_queue_ptrs (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire mq_pkg::mq_apb_req_s i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [mq_pkg::NUM_OWN-1:0] i_use,
  output logic [mq_pkg::NUM_OWN-1:0][31:0] o_queue_addr
);
  import mq_pkg::*;

  logic [OFS_W-1:0] offs_ff [NUM_PTR];
  logic [BASE_W-1:0] base_ff;
  logic [2:0] size_ff;
  logic rrbp_ff;
  logic dis_ff;
  logic [31:0] rdata;
  logic wr;
  mq_dec_s dec;
  logic [NUM_OWN-1:0] adv_take;
  logic [NUM_OWN-1:0][OFS_W-1:0] adv_next;
  logic in_post_eq;
  logic out_free_eq;

  mq_apb_slv u_apb (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_apb(i_apb),
    .i_rdata(rdata),
    .o_dec(dec),
    .o_wr(wr),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr)
  );

  // one advance unit per device-owned pointer
  for (genvar g = 0; g < NUM_OWN; g++) begin : g_adv
    mq_ptr_adv u_adv (
      .i_offset(offs_ff[OWNED_IDX[g]]),
      .i_size(size_ff),
      .i_use(i_use[g]),
      .i_disabled(dis_ff),
      .o_take(adv_take[g]),
      .o_next(adv_next[g])
    );
    // full queue address; all ones while queues are off
    assign o_queue_addr[g] = dis_ff ? ALL_ONES : {base_ff, offs_ff[OWNED_IDX[g]], 2'b00};
  end

  // control register
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      base_ff <= BASE_RST;
      size_ff <= SIZE_RST;
      rrbp_ff <= RRBP_RST;
      dis_ff <= DIS_RST;
    end else if (wr && dec.is_ctrl) begin
      base_ff <= i_apb.pwdata[31:BASE_LSB];
      size_ff <= i_apb.pwdata[CTRL_SIZE_MSB:CTRL_SIZE_LSB];
      rrbp_ff <= i_apb.pwdata[CTRL_RRBP_BIT];
      dis_ff <= i_apb.pwdata[CTRL_DIS_BIT];
    end
  end

  // pointer storage; a software write wins over an advance
  always_ff @(posedge i_mclk) begin
    for (int i = 0; i < NUM_PTR; i++) begin
      if (i_srst) begin
        offs_ff[i] <= PTR_RST;
      end else if (wr && !dec.is_ctrl && dec.idx == 3'(i)) begin
        offs_ff[i] <= i_apb.pwdata[BASE_LSB-1:OFS_LSB];
      end else begin
        for (int g = 0; g < NUM_OWN; g++) begin
          if (adv_take[g] && OWNED_IDX[g] == 3'(i)) begin
            offs_ff[i] <= adv_next[g];
          end
        end
      end
    end
  end

  assign in_post_eq = offs_ff[IDX_IN_POST_TOP] == offs_ff[IDX_IN_POST_BOT];
  assign out_free_eq = offs_ff[IDX_OUT_FREE_TOP] == offs_ff[IDX_OUT_FREE_BOT];

  // read word for the addressed register
  always_comb begin
    rdata = RD_ZERO;
    if (dec.is_ctrl) begin
      rdata[31:BASE_LSB] = base_ff;
      rdata[CTRL_SIZE_MSB:CTRL_SIZE_LSB] = size_ff;
      rdata[CTRL_RRBP_BIT] = rrbp_ff;
      rdata[CTRL_DIS_BIT] = dis_ff;
    end else begin
      rdata = {base_ff, offs_ff[dec.idx], 2'b00};
      if (rrbp_ff && dec.idx == IDX_IN_POST_BOT && in_post_eq) begin
        rdata = ALL_ONES;
      end
      if (rrbp_ff && dec.idx == IDX_OUT_FREE_BOT && out_free_eq) begin
        rdata = ALL_ONES;
      end
    end
  end

  // helper state for checks
  logic [OFS_W-1:0] chk_wval_q;
  logic [2:0] chk_widx_q;
  logic chk_wptr_q;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      chk_wval_q <= PTR_RST;
      chk_widx_q <= 3'h0;
      chk_wptr_q <= 1'b0;
    end else begin
      chk_wval_q <= i_apb.pwdata[BASE_LSB-1:OFS_LSB];
      chk_widx_q <= dec.idx;
      chk_wptr_q <= wr & ~dec.is_ctrl;
    end
  end

  sequence s_setup;
    i_apb.psel && !i_apb.penable;
  endsequence

  sequence s_access;
    i_apb.psel && i_apb.penable;
  endsequence

  sequence s_ptr_read;
    s_setup and (!i_apb.pwrite && dec.hit && !dec.is_ctrl && !rrbp_ff);
  endsequence

  sequence s_read_of(logic [11:0] a);
    s_setup and (!i_apb.pwrite && i_apb.paddr == a);
  endsequence

  property p_pready;
    @(posedge i_mclk) disable iff (i_srst)
      s_setup ##1 s_access |-> o_pready;
  endproperty
  a_pready: assert property (p_pready) else $error("access phase without pready");

  property p_base_read;
    @(posedge i_mclk) disable iff (i_srst)
      s_ptr_read |=> o_prdata[31:20] == $past(base_ff);
  endproperty
  a_base_read: assert property (p_base_read) else $error("base field wrong on read");

  property p_rsvd_read;
    @(posedge i_mclk) disable iff (i_srst)
      s_ptr_read |=> o_prdata[1:0] == 2'b00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits not zero");

  property p_ptr_write;
    @(posedge i_mclk) disable iff (i_srst)
      chk_wptr_q |-> offs_ff[chk_widx_q] == chk_wval_q;
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer write not stored");

  property p_adv_step(int unsigned g, logic [2:0] k);
    @(posedge i_mclk) disable iff (i_srst)
      (i_use[g] && !dis_ff && size_ff == SIZE_256 && !wr && offs_ff[k][7:0] != 8'hFF)
      |=> offs_ff[k][7:0] == $past(offs_ff[k][7:0]) + 8'h01
          && offs_ff[k][17:8] == $past(offs_ff[k][17:8]);
  endproperty
  a_adv_step: assert property (p_adv_step(0, IDX_IN_FREE_BOT)) else $error("no step");

  property p_adv_wrap(int unsigned g, logic [2:0] k);
    @(posedge i_mclk) disable iff (i_srst)
      (i_use[g] && !dis_ff && size_ff == SIZE_256 && !wr && offs_ff[k][7:0] == 8'hFF)
      |=> offs_ff[k][7:0] == 8'h00 && offs_ff[k][17:8] == $past(offs_ff[k][17:8]);
  endproperty
  a_adv_wrap: assert property (p_adv_wrap(1, IDX_IN_POST_TOP)) else $error("no wrap");

  property p_adv_big(int unsigned g, logic [2:0] k);
    @(posedge i_mclk) disable iff (i_srst)
      (i_use[g] && !dis_ff && size_ff == SIZE_64K && !wr && offs_ff[k][15:0] == 16'hFFFF)
      |=> offs_ff[k][15:0] == 16'h0000 && offs_ff[k][17:16] == $past(offs_ff[k][17:16]);
  endproperty
  a_adv_big: assert property (p_adv_big(2, IDX_OUT_FREE_TOP)) else $error("bad 64K wrap");
  a_size_max: assert property (p_adv_big(0, IDX_IN_FREE_BOT)) else $error("size 64K");
  a_adv_step_1: assert property (p_adv_step(1, IDX_IN_POST_TOP)) else $error("no step");
  a_adv_step_2: assert property (p_adv_step(2, IDX_OUT_FREE_TOP)) else $error("no step");
  a_adv_wrap_0: assert property (p_adv_wrap(0, IDX_IN_FREE_BOT)) else $error("no wrap");
  a_adv_wrap_2: assert property (p_adv_wrap(2, IDX_OUT_FREE_TOP)) else $error("no wrap");
  a_adv_big_1: assert property (p_adv_big(1, IDX_IN_POST_TOP)) else $error("bad wrap");

  property p_host_ptr;
    @(posedge i_mclk) disable iff (i_srst)
      !wr |=> $stable(offs_ff[IDX_IN_POST_BOT]) && $stable(offs_ff[IDX_OUT_FREE_BOT])
              && $stable(offs_ff[IDX_OUT_POST_TOP]);
  endproperty
  a_host_ptr: assert property (p_host_ptr) else $error("host pointer moved");

  property p_reset;
    @(posedge i_mclk) i_srst |=> base_ff == BASE_RST && offs_ff[IDX_IN_FREE_BOT] == PTR_RST
      && offs_ff[IDX_OUT_POST_TOP] == PTR_RST && o_queue_addr[0] == 32'h00000000;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear");

  property p_rrbp;
    @(posedge i_mclk) disable iff (i_srst)
      (s_setup and (!i_apb.pwrite && i_apb.paddr == IN_POST_BOT_OFS && rrbp_ff && in_post_eq))
      ##1 s_access |-> o_prdata == ALL_ONES;
  endproperty
  a_rrbp: assert property (p_rrbp) else $error("equal pointers not all ones");

  property p_disabled;
    @(posedge i_mclk) disable iff (i_srst)
      (dis_ff && !wr) [*2] |-> o_queue_addr[1] == ALL_ONES && $stable(offs_ff[IDX_IN_POST_TOP]);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled queue moved");

  property p_rrbp_out;
    @(posedge i_mclk) disable iff (i_srst)
      (s_read_of(OUT_FREE_BOT_OFS) and (rrbp_ff && out_free_eq)) ##1 s_access
      |-> o_prdata == ALL_ONES;
  endproperty
  a_rrbp_out: assert property (p_rrbp_out) else $error("outbound equal not all ones");

  property p_adv_rsvd(int unsigned g, logic [2:0] k);
    @(posedge i_mclk) disable iff (i_srst)
      (i_use[g] && !dis_ff && size_ff > SIZE_64K && !wr && offs_ff[k][15:0] == 16'hFFFF)
      |=> offs_ff[k][15:0] == 16'h0000 && offs_ff[k][17:16] == $past(offs_ff[k][17:16]);
  endproperty
  a_adv_rsvd: assert property (p_adv_rsvd(0, IDX_IN_FREE_BOT)) else $error("no wrap");
  a_adv_rsvd_1: assert property (p_adv_rsvd(1, IDX_IN_POST_TOP)) else $error("no wrap");
  a_adv_rsvd_2: assert property (p_adv_rsvd(2, IDX_OUT_FREE_TOP)) else $error("no wrap");

  property p_adv_1k;
    @(posedge i_mclk) disable iff (i_srst)
      (i_use[1] && !dis_ff && size_ff == 3'h1 && !wr
        && offs_ff[IDX_IN_POST_TOP][9:0] == 10'h3FF)
      |=> offs_ff[IDX_IN_POST_TOP][9:0] == 10'h000
          && offs_ff[IDX_IN_POST_TOP][17:10] == $past(offs_ff[IDX_IN_POST_TOP][17:10]);
  endproperty
  a_adv_1k: assert property (p_adv_1k) else $error("bad 1K wrap");

  property p_adv_hold;
    @(posedge i_mclk) disable iff (i_srst)
      (!wr && i_use == 3'h0) |=> $stable(offs_ff[IDX_IN_FREE_BOT])
        && $stable(offs_ff[IDX_IN_POST_TOP]) && $stable(offs_ff[IDX_OUT_FREE_TOP]);
  endproperty
  a_adv_hold: assert property (p_adv_hold) else $error("owned pointer moved");

  property p_adv_off;
    @(posedge i_mclk) disable iff (i_srst)
      (dis_ff && !wr) |=> $stable(offs_ff[IDX_IN_FREE_BOT])
        && $stable(offs_ff[IDX_OUT_FREE_TOP]);
  endproperty
  a_adv_off: assert property (p_adv_off) else $error("disabled pointer moved");

  property p_ptr_base_ro;
    @(posedge i_mclk) disable iff (i_srst)
      (wr && !dec.is_ctrl) |=> $stable(base_ff);
  endproperty
  a_ptr_base_ro: assert property (p_ptr_base_ro) else $error("pointer write moved base");

  property p_rd_ptr;
    @(posedge i_mclk) disable iff (i_srst)
      s_ptr_read |=> o_prdata[19:2] == $past(offs_ff[dec.idx]);
  endproperty
  a_rd_ptr: assert property (p_rd_ptr) else $error("offset wrong on read");

  property p_ctrl_wr;
    @(posedge i_mclk) disable iff (i_srst)
      (wr && dec.is_ctrl) |=> base_ff == $past(i_apb.pwdata[31:BASE_LSB])
        && size_ff == $past(i_apb.pwdata[CTRL_SIZE_MSB:CTRL_SIZE_LSB])
        && rrbp_ff == $past(i_apb.pwdata[CTRL_RRBP_BIT])
        && dis_ff == $past(i_apb.pwdata[CTRL_DIS_BIT]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write not stored");

  property p_reset_all;
    @(posedge i_mclk) i_srst |=> offs_ff[IDX_IN_POST_TOP] == PTR_RST
      && offs_ff[IDX_IN_POST_BOT] == PTR_RST && offs_ff[IDX_OUT_FREE_TOP] == PTR_RST
      && offs_ff[IDX_OUT_FREE_BOT] == PTR_RST && o_prdata == RD_ZERO;
  endproperty
  a_reset_all: assert property (p_reset_all) else $error("reset left a pointer set");

  property p_pslverr;
    @(posedge i_mclk) disable iff (i_srst)
      (s_setup and !dec.hit) ##1 s_access |-> o_pslverr && o_prdata == RD_ZERO;
  endproperty
  a_pslverr: assert property (p_pslverr) else $error("unmapped access not refused");

  property p_wr_rdata;
    @(posedge i_mclk) disable iff (i_srst)
      (s_setup and (i_apb.pwrite && dec.hit)) ##1 s_access |-> o_prdata == RD_ZERO && !o_pslverr;
  endproperty
  a_wr_rdata: assert property (p_wr_rdata) else $error("write answer wrong");

endmodule

//--- tb/mq_host_mdl.sv
// host-side apb master model for the queue pointer block
`timescale 1ns/1ps
module mq_host_mdl (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic i_wr,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  output mq_pkg::mq_apb_req_s o_apb,
  output logic [31:0] o_rdata,
  output logic o_err,
  output logic o_done
);
  import mq_pkg::*;
  initial o_apb = '0;
  initial o_rdata = 32'h0;
  initial o_err = 1'b0;
  initial o_done = 1'b0;
  always @(posedge i_mclk) begin
    o_done <= 1'b0;
    if (o_apb.psel && o_apb.penable && i_pready) begin
      // released bus shows the inverse of the last values
      o_apb <= '{1'b0, 1'b0, ~o_apb.pwrite, ~o_apb.paddr, ~o_apb.pwdata};
      o_rdata <= i_prdata;
      o_err <= i_pslverr;
      o_done <= 1'b1;
    end else if (o_apb.psel) begin
      o_apb.penable <= 1'b1;
    end else if (i_go && !o_done) begin
      o_apb <= '{1'b1, 1'b0, i_wr, i_addr, i_wdata};
    end
  end
endmodule

//--- tb/mq_queue_ptrs_test.sv
// self-checking bench for the message queue pointer block
`timescale 1ns/1ps
module mq_queue_ptrs_test;
  import mq_pkg::*;
  localparam logic [11:0] PA [6] = '{IN_FREE_BOT_OFS, IN_POST_TOP_OFS,
    IN_POST_BOT_OFS, OUT_FREE_TOP_OFS, OUT_FREE_BOT_OFS, OUT_POST_TOP_OFS};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [11:0] ad = 12'h000;
  logic [31:0] wd = 32'h00000000;
  logic [2:0] use_p = 3'h0;
  mq_apb_req_s apb;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic done;
  logic [2:0][31:0] qa;
  logic [31:0] hv [6];
  logic [31:0] e;
  logic [17:0] ofs;
  logic [11:0] base;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  mq_queue_ptrs mq_queue_ptrs_i (.i_mclk(clk), .i_srst(rst), .i_apb(apb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_use(use_p), .o_queue_addr(qa));
  mq_host_mdl mq_host_mdl_i (.i_mclk(clk), .i_go(go), .i_wr(wr), .i_addr(ad),
    .i_wdata(wd), .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata),
    .o_apb(apb), .o_rdata(rd), .o_err(err), .o_done(done));
  task automatic end_of_test();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    go <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      #1;
    end while (done !== 1'b1);
  endtask
  task automatic ctrl(input logic [2:0] s, input logic rr, input logic dis);
    bus(1'b1, CTRL_OFS, {base, 13'h0, s, 2'b00, rr, dis});
  endtask
  task automatic pulse(input logic [2:0] u, input int len);
    @(posedge clk);
    use_p <= u;
    repeat (len) @(posedge clk);
    use_p <= 3'h0;
    #1;
  endtask
  function automatic logic [17:0] wmask(input int s);
    return (18'h100 << (2 * (s > 4 ? 4 : s))) - 18'h1;
  endfunction
  function automatic logic [31:0] adv(input logic [17:0] o, input int s);
    return {base, (o & ~wmask(s)) | ((o + 18'h1) & wmask(s)), 2'b00};
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(3457));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (PA[k]) begin
      bus(1'b0, PA[k], 32'h0);
      chk(rd, 32'h0);
    end
    base = 12'($urandom);
    ctrl(3'h0, 1'b0, 1'b0);
    foreach (PA[k]) begin
      hv[k] = $urandom;
      bus(1'b1, PA[k], hv[k]);
      bus(1'b0, PA[k], 32'h0);
      chk(rd, {base, hv[k][19:2], 2'b00});
    end
    bus(1'b0, 12'h204, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    for (int s = 0; s <= 5; s++) begin
      ctrl(3'(s), 1'b0, 1'b0);
      for (int g = 0; g < 3; g++) begin
        ofs = 18'($urandom) | wmask(s);
        bus(1'b1, PA[OWNED_IDX[g]], {12'h0, ofs, 2'b00});
        pulse(3'h1 << g, 2);
        e = adv(ofs, s);
        chk(qa[g], adv(e[19:2], s));
      end
    end
    pulse(3'h7, 3);
    foreach (PA[k]) begin
      if (k == 2 || k == 4 || k == 5) begin
        bus(1'b0, PA[k], 32'h0);
        chk(rd, {base, hv[k][19:2], 2'b00});
      end
    end
    ctrl(3'h0, 1'b1, 1'b0);
    for (int q = 1; q < 4; q += 2) begin
      e = $urandom;
      bus(1'b1, PA[q], e);
      bus(1'b1, PA[q+1], e);
      bus(1'b0, PA[q+1], 32'h0);
      chk(rd, ALL_ONES);
      bus(1'b0, PA[q], 32'h0);
      chk(rd, {base, e[19:2], 2'b00});
      bus(1'b1, PA[q+1], ~e);
      bus(1'b0, PA[q+1], 32'h0);
      chk(rd, {base, ~e[19:2], 2'b00});
    end
    bus(1'b1, IN_FREE_BOT_OFS, e);
    ctrl(3'h0, 1'b0, 1'b1);
    chk(qa[0], ALL_ONES);
    chk(qa[2], ALL_ONES);
    pulse(3'h7, 2);
    ctrl(3'h0, 1'b0, 1'b0);
    chk(qa[0], {base, e[19:2], 2'b00});
    end_of_test();
  end
endmodule
